// *** rtl/cct_params.svh ***
`ifndef CCT_PARAMS_SVH
`define CCT_PARAMS_SVH

// register indices on the plain register port
`define CCT_OFS_COUNT      4'h0
`define CCT_OFS_GEN_A      4'h1
`define CCT_OFS_GEN_B      4'h2
`define CCT_OFS_BUF_C      4'h3
`define CCT_OFS_BUF_D      4'h4
`define CCT_OFS_MODE       4'h5
`define CCT_OFS_CONTROL    4'h6
`define CCT_OFS_IO_CTRL    4'h7
`define CCT_OFS_IRQ_EN     4'h8
`define CCT_OFS_FLAGS      4'h9

// mode register fields
`define CCT_MODE_RUN       7
`define CCT_MODE_DIR       1
`define CCT_MODE_PWM       0

// control register fields
`define CCT_CTL_CLR_HI     6
`define CCT_CTL_CLR_LO     5
`define CCT_CTL_CKS_HI     2
`define CCT_CTL_CKS_LO     0

// io control register fields
`define CCT_IO_BUF_B       7
`define CCT_IO_CAP_B       6
`define CCT_IO_ACT_B_HI    5
`define CCT_IO_ACT_B_LO    4
`define CCT_IO_BUF_A       3
`define CCT_IO_CAP_A       2
`define CCT_IO_ACT_A_HI    1
`define CCT_IO_ACT_A_LO    0

// flag and enable bit positions (same in both registers)
`define CCT_FLG_OVF        3
`define CCT_FLG_UDF        2
`define CCT_FLG_B          1
`define CCT_FLG_A          0

// reset values
`define CCT_RST_GEN        16'hFFFF
`define CCT_RST_REG8       8'h00
`define CCT_RST_CNT        16'h0000
`define CCT_PWM_INIT_LVL   1'b0

`endif

// *** rtl/cct_pkg.sv ***
package cct_pkg;

   // pins arriving from outside, all asynchronous to the system clock
   typedef struct packed {
      logic clk_b;   // external count input b / phase input b
      logic clk_a;   // external count input a / phase input a
      logic cap_b;   // capture input of channel b
      logic cap_a;   // capture input of channel a
   } pin_in_s;

   // one driven pin: level plus output enable
   typedef struct packed {
      logic lvl;
      logic oe;
   } pin_out_s;

   // compare output action, also capture edge select in capture use
   typedef enum logic [1:0] {
      ACT_HOLD   = 2'h0,
      ACT_LOW    = 2'h1,
      ACT_HIGH   = 2'h2,
      ACT_TOGGLE = 2'h3
   } out_act_e;

   // counter clear source
   typedef enum logic [1:0] {
      CLR_NONE  = 2'h0,
      CLR_BY_A  = 2'h1,
      CLR_BY_B  = 2'h2,
      CLR_NEVER = 2'h3
   } clr_src_e;

   // count source select
   typedef enum logic [2:0] {
      CKS_DIV1  = 3'h0,
      CKS_DIV2  = 3'h1,
      CKS_DIV4  = 3'h2,
      CKS_DIV8  = 3'h3,
      CKS_DIV32 = 3'h4,
      CKS_EXT_A = 3'h5,
      CKS_NONE  = 3'h6,
      CKS_EXT_B = 3'h7
   } clk_sel_e;

endpackage : cct_pkg

// *** rtl/capture_compare_pwm_timer.sv ***
// What this block does
// RULE1 - capture select set: capture counter into general register
// RULE2 - channel a compare: match drives configured level
// RULE3 - channel b compare: match drives configured level
// RULE4 - pwm mode: match a drives pin a high
// RULE5 - pwm mode: match b drives pin a low
// RULE6 - buffer a capture: old a moves into c
// RULE7 - buffer a compare: match a reloads a from c
// RULE8 - buffer b capture: old b moves into d
// RULE9 - buffer b: match b reloads b from d
// RULE10 - direction bit selects increment or phase counting
// RULE11 - mode bit 0 selects timer or pwm
// RULE12 - io bit 7 enables buffer d
// RULE13 - io bit 3 enables buffer c
// RULE14 - enable bit 3 gates overflow interrupt
// RULE15 - enable bit 1 gates channel b interrupt
// RULE16 - enable bit 0 gates channel a interrupt
// RULE17 - run cleared stops count, resets pwm pin
// RULE18 - clear source: none, by a, by b
// RULE19 - compare match sets channel flag
// RULE20 - flag clears only by read then write 0
// RULE21 - interrupt while any enabled flag set
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cct_params.svh"

module capture_compare_pwm_timer #(
   parameter int CNT_W = 16    // counter and general register width
) (
   // clock and reset
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst,
   // register port
   input  wire logic [3:0]         i_addr,
   input  wire logic [CNT_W-1:0]   i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic      [CNT_W-1:0]   o_rdata,
   // pins
   input  wire cct_pkg::pin_in_s   i_pins,
   output cct_pkg::pin_out_s       o_pin_a,
   output cct_pkg::pin_out_s       o_pin_b,
   // interrupt request
   output logic                    o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [3:0]       sync1_reg, sync2_reg, prev_reg;   // pin synchronisers
   logic [4:0]       div_reg, div_next;                // prescaler
   logic [CNT_W-1:0] count_reg, count_next;            // count_value
   logic [CNT_W-1:0] gen_a_reg, gen_a_next;            // general_reg_a
   logic [CNT_W-1:0] gen_b_reg, gen_b_next;            // general_reg_b
   logic [CNT_W-1:0] buf_c_reg, buf_c_next;            // buffer_reg_c
   logic [CNT_W-1:0] buf_d_reg, buf_d_next;            // buffer_reg_d
   logic [7:0]       mode_reg, mode_next;              // mode_reg
   logic [7:0]       ctl_reg, ctl_next;                // control_reg
   logic [7:0]       io_reg, io_next;                  // io_control_reg
   logic [3:0]       ien_reg, ien_next;                // irq_enable_reg
   logic [3:0]       flag_reg, flag_next;              // flag_reg
   logic [3:0]       armed_reg, armed_next;            // flags seen as 1 by a read
   logic             pin_a_reg, pin_a_next;            // output_pin_a level
   logic             pin_b_reg, pin_b_next;            // output_pin_b level
   logic             irq_reg, irq_next;
   logic [CNT_W-1:0] rdata_reg, rdata_next;

   ////////////////////////////////////////////////////////////////////////
   // decoded controls and events
   logic             run, pwm, dir, buf_a, buf_b, cap_a, cap_b;
   logic             cmp_a, cmp_b;           // channel in compare use
   logic             rise_ca, rise_cb, fall_ca;
   logic             tick, inc, dec, cnt_evt;
   logic             match_a, match_b, capt_a, capt_b, clear_evt;
   logic             ovf, udf;
   logic [3:0]       flag_set, flag_clr;
   cct_pkg::out_act_e act_a, act_b;
   cct_pkg::clr_src_e clr_src;
   cct_pkg::clk_sel_e clk_sel;

   // capture edge test for one synchronised pin
   function automatic logic cap_edge(input logic cur, input logic old, input cct_pkg::out_act_e sel);
      logic r;
      r = 1'b0;
      case (sel)
         cct_pkg::ACT_HOLD: r = cur & ~old;   // rising edge
         cct_pkg::ACT_LOW:  r = ~cur & old;   // falling edge
         default:           r = cur ^ old;    // both edges
      endcase
      return r;
   endfunction : cap_edge

   // compare action applied to the present pin level
   function automatic logic cmp_level(input logic cur, input cct_pkg::out_act_e act);
      logic r;
      r = cur;
      case (act)
         cct_pkg::ACT_LOW:    r = 1'b0;
         cct_pkg::ACT_HIGH:   r = 1'b1;
         cct_pkg::ACT_TOGGLE: r = ~cur;
         default:             r = cur;
      endcase
      return r;
   endfunction : cmp_level

   ////////////////////////////////////////////////////////////////////////
   // field decode and event detection
   always_comb begin
      run     = mode_reg[`CCT_MODE_RUN];
      pwm     = mode_reg[`CCT_MODE_PWM];                        // [RULE11]
      dir     = mode_reg[`CCT_MODE_DIR];
      buf_a   = io_reg[`CCT_IO_BUF_A];                          // [RULE13]
      buf_b   = io_reg[`CCT_IO_BUF_B];                          // [RULE12]
      cap_a   = io_reg[`CCT_IO_CAP_A];
      cap_b   = io_reg[`CCT_IO_CAP_B];
      act_a   = cct_pkg::out_act_e'(io_reg[`CCT_IO_ACT_A_HI:`CCT_IO_ACT_A_LO]);
      act_b   = cct_pkg::out_act_e'(io_reg[`CCT_IO_ACT_B_HI:`CCT_IO_ACT_B_LO]);
      clr_src = cct_pkg::clr_src_e'(ctl_reg[`CCT_CTL_CLR_HI:`CCT_CTL_CLR_LO]);
      clk_sel = cct_pkg::clk_sel_e'(ctl_reg[`CCT_CTL_CKS_HI:`CCT_CTL_CKS_LO]);
      // pwm mode forces channel a into compare use, channel b too
      cmp_a   = pwm | ~cap_a;
      cmp_b   = pwm | ~cap_b;
      // edges on the external clock pins, from the second stage onward
      rise_ca = sync2_reg[2] & ~prev_reg[2];
      fall_ca = ~sync2_reg[2] & prev_reg[2];
      rise_cb = sync2_reg[3] & ~prev_reg[3];
      // count source; the prescaler runs freely so a change of rate
      // takes effect without restarting it
      case (clk_sel)
         cct_pkg::CKS_DIV1:  tick = 1'b1;
         cct_pkg::CKS_DIV2:  tick = div_reg[0];
         cct_pkg::CKS_DIV4:  tick = &div_reg[1:0];
         cct_pkg::CKS_DIV8:  tick = &div_reg[2:0];
         cct_pkg::CKS_DIV32: tick = &div_reg[4:0];
         cct_pkg::CKS_EXT_A: tick = rise_ca;
         cct_pkg::CKS_EXT_B: tick = rise_cb;
         default:            tick = 1'b0;   // prohibited code counts nothing
      endcase
      // phase counting: edges of a, direction from the level of b
      if (dir) begin                                            // [RULE10]
         inc = run & ((rise_ca & ~sync2_reg[3]) | (fall_ca & sync2_reg[3]));
         dec = run & ((rise_ca & sync2_reg[3]) | (fall_ca & ~sync2_reg[3]));
      end else begin
         inc = run & tick;                                      // [RULE10]
         dec = 1'b0;
      end
      cnt_evt = inc | dec;
      // a match is taken as the counter leaves the matching value
      match_a = cnt_evt & cmp_a & (count_reg == gen_a_reg);
      match_b = cnt_evt & cmp_b & (count_reg == gen_b_reg);
      capt_a  = ~pwm & cap_a & cap_edge(sync2_reg[0], prev_reg[0], act_a);
      capt_b  = ~pwm & cap_b & cap_edge(sync2_reg[1], prev_reg[1], act_b);
      case (clr_src)                                            // [RULE18]
         cct_pkg::CLR_BY_A: clear_evt = match_a | capt_a;
         cct_pkg::CLR_BY_B: clear_evt = match_b | capt_b;
         default:           clear_evt = 1'b0;
      endcase
      ovf = inc & (&count_reg) & ~clear_evt;
      udf = dec & (count_reg == '0) & ~clear_evt;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state of counter, registers, pins and flags
   always_comb begin
      div_next   = div_reg + 5'h01;
      count_next = count_reg;
      gen_a_next = gen_a_reg;
      gen_b_next = gen_b_reg;
      buf_c_next = buf_c_reg;
      buf_d_next = buf_d_reg;
      mode_next  = mode_reg;
      ctl_next   = ctl_reg;
      io_next    = io_reg;
      ien_next   = ien_reg;
      armed_next = armed_reg;
      pin_a_next = pin_a_reg;
      pin_b_next = pin_b_reg;
      flag_clr   = 4'h0;
      rdata_next = '0;

      // software writes; hardware transfers below take precedence
      if (i_wr) begin
         case (i_addr)
            `CCT_OFS_COUNT:   count_next = i_wdata;
            `CCT_OFS_GEN_A:   gen_a_next = i_wdata;
            `CCT_OFS_GEN_B:   gen_b_next = i_wdata;
            `CCT_OFS_BUF_C:   buf_c_next = i_wdata;
            `CCT_OFS_BUF_D:   buf_d_next = i_wdata;
            `CCT_OFS_MODE:    mode_next  = i_wdata[7:0];
            `CCT_OFS_CONTROL: ctl_next   = {1'b0, i_wdata[6:0]};
            `CCT_OFS_IO_CTRL: io_next    = i_wdata[7:0];
            `CCT_OFS_IRQ_EN:  ien_next   = i_wdata[3:0];
            `CCT_OFS_FLAGS: begin
               // only a flag read as 1 beforehand can be cleared by 0
               flag_clr   = armed_reg & ~i_wdata[3:0];          // [RULE20]
               armed_next = 4'h0;
            end
            default: ;                                          // unmapped: ignored
         endcase
      end

      // read data, one cycle later; unmapped reads give zero
      if (i_rd) begin
         case (i_addr)
            `CCT_OFS_COUNT:   rdata_next = count_reg;
            `CCT_OFS_GEN_A:   rdata_next = gen_a_reg;
            `CCT_OFS_GEN_B:   rdata_next = gen_b_reg;
            `CCT_OFS_BUF_C:   rdata_next = buf_c_reg;
            `CCT_OFS_BUF_D:   rdata_next = buf_d_reg;
            `CCT_OFS_MODE:    rdata_next = {8'h00, mode_reg};
            `CCT_OFS_CONTROL: rdata_next = {8'h00, ctl_reg};
            `CCT_OFS_IO_CTRL: rdata_next = {8'h00, io_reg};
            `CCT_OFS_IRQ_EN:  rdata_next = {12'h000, ien_reg};
            `CCT_OFS_FLAGS: begin
               rdata_next = {12'h000, flag_reg};
               armed_next = flag_reg;                           // [RULE20]
            end
            default:          rdata_next = '0;
         endcase
      end

      // counter: clear beats count, stopped counter holds unless a capture clears it
      if (clear_evt)
         count_next = '0;                                       // [RULE18]
      else if (inc)
         count_next = count_reg + 16'h0001;                     // [RULE10]
      else if (dec)
         count_next = count_reg - 16'h0001;

      // channel a: capture, or compare reload from the buffer
      if (capt_a) begin
         gen_a_next = count_reg;                                // [RULE1]
         if (buf_a)
            buf_c_next = gen_a_reg;                             // [RULE6]
      end else if (match_a && buf_a) begin
         gen_a_next = buf_c_reg;                                // [RULE7]
      end
      // channel b likewise, pwm included
      if (capt_b) begin
         gen_b_next = count_reg;                                // [RULE1]
         if (buf_b)
            buf_d_next = gen_b_reg;                             // [RULE8]
      end else if (match_b && buf_b) begin
         gen_b_next = buf_d_reg;                                // [RULE9]
      end

      // pin levels
      if (pwm) begin
         if (!run)
            pin_a_next = `CCT_PWM_INIT_LVL;                     // [RULE17]
         else if (match_b)
            pin_a_next = 1'b0;                                  // [RULE5]
         else if (match_a)
            pin_a_next = 1'b1;                                  // [RULE4]
      end else begin
         if (match_a)
            pin_a_next = cmp_level(pin_a_reg, act_a);           // [RULE2]
         if (match_b)
            pin_b_next = cmp_level(pin_b_reg, act_b);           // [RULE3]
      end

      // flags: a set in the clearing cycle wins
      flag_set = {ovf, udf, match_b | capt_b, match_a | capt_a};   // [RULE19]
      flag_next = (flag_reg & ~flag_clr) | flag_set;               // [RULE20]
      irq_next  = |(flag_next & ien_reg);              // [RULE14] [RULE15] [RULE16] [RULE21]
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         prev_reg  <= 4'h0;
         div_reg   <= 5'h00;
         count_reg <= `CCT_RST_CNT;
         gen_a_reg <= `CCT_RST_GEN;
         gen_b_reg <= `CCT_RST_GEN;
         buf_c_reg <= `CCT_RST_GEN;
         buf_d_reg <= `CCT_RST_GEN;
         mode_reg  <= `CCT_RST_REG8;
         ctl_reg   <= `CCT_RST_REG8;
         io_reg    <= `CCT_RST_REG8;
         ien_reg   <= 4'h0;
         flag_reg  <= 4'h0;
         armed_reg <= 4'h0;
         pin_a_reg <= `CCT_PWM_INIT_LVL;
         pin_b_reg <= 1'b0;
         irq_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         sync1_reg <= i_pins;         // first stage, read only by the second
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         div_reg   <= div_next;
         count_reg <= count_next;
         gen_a_reg <= gen_a_next;
         gen_b_reg <= gen_b_next;
         buf_c_reg <= buf_c_next;
         buf_d_reg <= buf_d_next;
         mode_reg  <= mode_next;
         ctl_reg   <= ctl_next;
         io_reg    <= io_next;
         ien_reg   <= ien_next;
         flag_reg  <= flag_next;
         armed_reg <= armed_next;
         pin_a_reg <= pin_a_next;
         pin_b_reg <= pin_b_next;
         irq_reg   <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs; pin b is not driven in pwm mode or while capturing
   assign o_rdata     = rdata_reg;
   assign o_irq       = irq_reg;
   // whole-struct drives: one continuous driver per output variable
   assign o_pin_a     = {pin_a_reg, cmp_a};
   assign o_pin_b     = {pin_b_reg, ~pwm & ~cap_b};

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_flag_read;
      i_rd && (i_addr == `CCT_OFS_FLAGS) && flag_reg[`CCT_FLG_A];
   endsequence
   // the bench tasks leave an idle cycle between two register accesses
   sequence s_no_flag_write;
      !(i_wr && (i_addr == `CCT_OFS_FLAGS));
   endsequence
   sequence s_flag_write0;
      i_wr && (i_addr == `CCT_OFS_FLAGS) && !i_wdata[`CCT_FLG_A] && !flag_set[`CCT_FLG_A];
   endsequence

   property p_capture_a;
      capt_a |=> gen_a_reg == $past(count_reg);
   endproperty
   a_capture_a: assert property (p_capture_a) else $error("capture a lost counter"); // [RULE1]

   property p_compare_a_low;
      (!pwm && match_a && act_a == cct_pkg::ACT_LOW) |=> !o_pin_a.lvl;
   endproperty
   a_compare_a_low: assert property (p_compare_a_low) else $error("pin a not low"); // [RULE2]

   property p_compare_b_high;
      (!pwm && match_b && act_b == cct_pkg::ACT_HIGH) |=> o_pin_b.lvl;
   endproperty
   a_compare_b_high: assert property (p_compare_b_high) else $error("pin b not high"); // [RULE3]

   property p_pwm_rise;
      (pwm && run && match_a && !match_b) |=> o_pin_a.lvl;
   endproperty
   a_pwm_rise: assert property (p_pwm_rise) else $error("pwm pin not high"); // [RULE4]

   property p_pwm_fall;
      (pwm && run && match_b) |=> !o_pin_a.lvl;
   endproperty
   a_pwm_fall: assert property (p_pwm_fall) else $error("pwm pin not low"); // [RULE5]

   property p_buf_c_capture;
      (capt_a && buf_a) |=> buf_c_reg == $past(gen_a_reg);
   endproperty
   a_buf_c_capture: assert property (p_buf_c_capture) else $error("c missed old a"); // [RULE6]

   property p_buf_c_reload;
      (match_a && buf_a) |=> gen_a_reg == $past(buf_c_reg);
   endproperty
   a_buf_c_reload: assert property (p_buf_c_reload) else $error("a not reloaded"); // [RULE7]

   property p_buf_d_capture;
      (capt_b && buf_b) |=> buf_d_reg == $past(gen_b_reg);
   endproperty
   a_buf_d_capture: assert property (p_buf_d_capture) else $error("d missed old b"); // [RULE8]

   property p_buf_d_reload;
      (match_b && buf_b) |=> gen_b_reg == $past(buf_d_reg);
   endproperty
   a_buf_d_reload: assert property (p_buf_d_reload) else $error("b not reloaded"); // [RULE9]

   property p_pwm_stop;
      (pwm && !run && !i_wr) |=> (o_pin_a.lvl == `CCT_PWM_INIT_LVL) && $stable(count_reg);
   endproperty
   a_pwm_stop: assert property (p_pwm_stop) else $error("stop did not reset pwm"); // [RULE17]

   property p_clear_by_a;
      (clr_src == cct_pkg::CLR_BY_A && match_a && !i_wr) |=> count_reg == '0;
   endproperty
   a_clear_by_a: assert property (p_clear_by_a) else $error("counter not cleared"); // [RULE18]

   property p_flag_clear;
      s_flag_read ##1 s_no_flag_write ##1 s_flag_write0 |=> !flag_reg[`CCT_FLG_A];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag a not cleared"); // [RULE20]

   property p_flag_hold;
      (flag_reg[`CCT_FLG_A] && !armed_reg[`CCT_FLG_A]) |=> flag_reg[`CCT_FLG_A];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag a cleared unread"); // [RULE20]

   property p_irq;
      ##1 o_irq == |($past(flag_next) & $past(ien_reg));
   endproperty
   a_irq: assert property (p_irq) else $error("irq wrong"); // [RULE21]

endmodule : capture_compare_pwm_timer

`default_nettype wire

// *** dv/ext_circuit.sv ***
`timescale 1ns/1ps
`default_nettype none

// far side of the timer pins: capture sources and a pulled-up line on pin a
module ext_circuit (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_rst,
   // pulse requests from the bench
   input  wire logic              i_pulse_a,
   input  wire logic              i_pulse_b,
   // pins of the timer
   input  wire cct_pkg::pin_out_s i_pin_a,
   output var cct_pkg::pin_in_s   o_pins,
   output logic                   o_line_a
);
   logic [2:0] hold_reg;   // cycles left in the current pulse

   ////////////////////////////////////////////////////////////////////////
   // pull-up: a released pin reads high, never the last driven level
   assign o_line_a = i_pin_a.oe ? i_pin_a.lvl : 1'b1;

   // pulses stay high five clocks so the synchroniser cannot miss them
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hold_reg <= 3'h0;
         o_pins   <= '0;
      end else if (i_pulse_a || i_pulse_b) begin
         hold_reg     <= 3'h4;
         o_pins.cap_a <= i_pulse_a;
         o_pins.cap_b <= i_pulse_b;
      end else if (hold_reg != 3'h0) begin
         hold_reg <= hold_reg - 3'h1;
      end else begin
         // idle: both capture lines low, count inputs unused
         o_pins <= '0;
      end
   end
endmodule : ext_circuit

`default_nettype wire

// *** dv/capture_compare_pwm_timer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cct_params.svh"

module capture_compare_pwm_timer_bench;
   // one register access: write, or read with its expected value
   typedef struct packed {
      logic        wr;
      logic [3:0]  addr;
      logic [15:0] data;
      logic [15:0] exp;
   } row_s;

   logic              clk = 1'b0;   // 50 MHz system clock
   logic              rst = 1'b1;   // synchronous reset
   logic              wr = 1'b0;    // write strobe
   logic              rd = 1'b0;    // read strobe
   logic              pa = 1'b0;    // capture pulse request a
   logic              pb = 1'b0;    // capture pulse request b
   logic [3:0]        addr = 4'h0;  // register index
   logic [15:0]       wdata = 16'h0;
   logic [15:0]       rdata;
   logic [15:0]       v;
   logic [15:0]       w;
   logic [15:0]       x;
   logic              irq;
   logic              line_a;
   cct_pkg::pin_in_s  pins;
   cct_pkg::pin_out_s pin_a;
   cct_pkg::pin_out_s pin_b;
   int                n_errors = 0;
   int                checks = 0;
   int                n;
   row_s              rows [17];

   ////////////////////////////////////////////////////////////////////////
   capture_compare_pwm_timer dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pins(pins), .o_pin_a(pin_a), .o_pin_b(pin_b),
      .o_irq(irq));
   ext_circuit partner (.i_clk_sys(clk), .i_rst(rst), .i_pulse_a(pa), .i_pulse_b(pb),
      .i_pin_a(pin_a), .o_pins(pins), .o_line_a(line_a));

   // free-running clock
   initial begin
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // strobes last one cycle; the next access waits one more edge
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe edge
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   // bounded count of settled cycles while line a holds lvl
   task automatic count_while(input logic lvl, output int c);
      c = 0;
      while (line_a === lvl && c < 60) begin
         @(posedge clk);
         #1 c++;
      end
      if (c == 60) begin
         $display("FAIL line a wait expected %b seen %b", ~lvl, line_a);
         n_errors++;
         finish_test();
      end
   endtask : count_while

   task automatic irq_case(input logic [15:0] en, input logic exp);
      wr_reg(`CCT_OFS_IRQ_EN, en);
      repeat (2) @(posedge clk);
      #1 chk("irq", {15'h0, exp}, {15'h0, irq});
   endtask : irq_case

   task automatic pulse;
      @(posedge clk);
      pa <= 1'b1;
      pb <= 1'b1;
      @(posedge clk);
      pa <= 1'b0;
      pb <= 1'b0;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{0, `CCT_OFS_COUNT, 16'h0, 16'h0000}, '{0, `CCT_OFS_GEN_A, 16'h0, 16'hFFFF},
         '{0, `CCT_OFS_GEN_B, 16'h0, 16'hFFFF}, '{0, `CCT_OFS_BUF_C, 16'h0, 16'hFFFF},
         '{0, `CCT_OFS_BUF_D, 16'h0, 16'hFFFF}, '{0, `CCT_OFS_MODE, 16'h0, 16'h0000},
         '{0, `CCT_OFS_CONTROL, 16'h0, 16'h0000}, '{0, `CCT_OFS_IO_CTRL, 16'h0, 16'h0000},
         '{0, `CCT_OFS_IRQ_EN, 16'h0, 16'h0000}, '{0, `CCT_OFS_FLAGS, 16'h0, 16'h0000},
         '{0, 4'hA, 16'h0, 16'h0000}, '{1, `CCT_OFS_IO_CTRL, 16'h0088, 16'h0},
         '{0, `CCT_OFS_IO_CTRL, 16'h0, 16'h0088}, '{1, `CCT_OFS_IRQ_EN, 16'h000B, 16'h0},
         '{0, `CCT_OFS_IRQ_EN, 16'h0, 16'h000B}, '{1, 4'hF, 16'h1234, 16'h0},
         '{0, 4'hF, 16'h0, 16'h0000}};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // reset values, read-back, unmapped index
      foreach (rows[i]) begin
         if (rows[i].wr) wr_reg(rows[i].addr, rows[i].data);
         else begin
            rd_reg(rows[i].addr, v);
            chk("register", rows[i].exp, v);
         end
      end
      // pwm, period 10 clear by a, duty point 3 then 5 from buffer d
      wr_reg(`CCT_OFS_GEN_A, 16'h0009);
      wr_reg(`CCT_OFS_GEN_B, 16'h0003);
      wr_reg(`CCT_OFS_BUF_D, 16'h0005);
      wr_reg(`CCT_OFS_CONTROL, 16'h0020);
      wr_reg(`CCT_OFS_IO_CTRL, 16'h0080);
      wr_reg(`CCT_OFS_IRQ_EN, 16'h0002);
      wr_reg(`CCT_OFS_MODE, 16'h0081);
      count_while(1'b0, n);
      count_while(1'b1, n);
      chk("pwm high", 16'h0006, n[15:0]);
      count_while(1'b0, n);
      chk("pwm low", 16'h0004, n[15:0]);
      // stop while high: pin a returns to its initial level
      wr_reg(`CCT_OFS_MODE, 16'h0001);
      repeat (2) @(posedge clk);
      #1 chk("pin a stop", 16'h0000, {15'h0, line_a});
      rd_reg(`CCT_OFS_GEN_B, v);
      chk("reload b", 16'h0005, v);
      rd_reg(`CCT_OFS_COUNT, v);
      rd_reg(`CCT_OFS_COUNT, w);
      chk("count stop", 16'h0002, v);
      chk("count held", 16'h0002, w);
      chk("pin b oe", 16'h0000, {15'h0, pin_b.oe});
      chk("irq b", 16'h0001, {15'h0, irq});
      irq_case(16'h0000, 1'b0);
      irq_case(16'h0008, 1'b0);
      irq_case(16'h0001, 1'b1);
      // a zero written without a prior read must not clear
      wr_reg(`CCT_OFS_FLAGS, 16'h0000);
      rd_reg(`CCT_OFS_FLAGS, v);
      chk("flags kept", 16'h0003, v);
      wr_reg(`CCT_OFS_FLAGS, 16'h0000);
      rd_reg(`CCT_OFS_FLAGS, v);
      chk("flags cleared", 16'h0000, v);
      chk("irq idle", 16'h0000, {15'h0, irq});
      // capture on both channels, two edges 32 clocks apart
      wr_reg(`CCT_OFS_CONTROL, 16'h0000);
      wr_reg(`CCT_OFS_IO_CTRL, 16'h00CC);
      wr_reg(`CCT_OFS_MODE, 16'h0080);
      pulse();
      repeat (30) @(posedge clk);
      pulse();
      repeat (10) @(posedge clk);
      rd_reg(`CCT_OFS_GEN_A, v);
      rd_reg(`CCT_OFS_BUF_C, w);
      chk("capture span", 16'h0020, v - w);
      rd_reg(`CCT_OFS_GEN_B, x);
      chk("capture b", v, x);
      rd_reg(`CCT_OFS_BUF_D, x);
      chk("buffer d", w, x);
      // compare: a goes high at 4 and reloads 7, b goes high at 6 and clears
      wr_reg(`CCT_OFS_MODE, 16'h0000);
      wr_reg(`CCT_OFS_COUNT, 16'h0000);
      wr_reg(`CCT_OFS_CONTROL, 16'h0040);
      wr_reg(`CCT_OFS_IO_CTRL, 16'h002A);
      wr_reg(`CCT_OFS_GEN_A, 16'h0004);
      wr_reg(`CCT_OFS_BUF_C, 16'h0007);
      wr_reg(`CCT_OFS_GEN_B, 16'h0006);
      wr_reg(`CCT_OFS_MODE, 16'h0080);
      repeat (30) @(posedge clk);
      wr_reg(`CCT_OFS_MODE, 16'h0000);
      #1 chk("pin a", 16'h0001, {15'h0, pin_a.lvl});
      chk("pin b", 16'h0001, {15'h0, pin_b.lvl});
      rd_reg(`CCT_OFS_GEN_A, v);
      chk("reload a", 16'h0007, v);
      rd_reg(`CCT_OFS_COUNT, v);
      chk("clear by b", 16'h0001, {15'h0, v < 16'h0007});
      finish_test();
   end
endmodule : capture_compare_pwm_timer_bench

`default_nettype wire
